// file: leit_interlock.sv
// Purpose: controller-side emission interlock and per-head response watchdog
// Assumes: heads end their own measurement; inputs synchronous to clk_in
// Notes:   safety relay contact is read only; no path can switch that relay
`timescale 1ns/1ps

// Operation
// - Up to eight heads are each supervised and have their own enable path.
// - The series enable relay closes only with software enable and head drive.
// - A head's PWM passes only while controller enable and head request agree.
// - Each head stage has its own enable line, off whenever it is deasserted.
// - Each head has a configured measurement time and is polled when it ends.
// - No response 500 ms after expected end drops the shared enable for all.
// - The safety relay contact is only read and no output can switch it.
// - After a safety fault laser power stays off until an external reset and a new software enable write.
module leit_interlock
    import leit_pkg::*;
#(
    parameter int unsigned HEADS    = NUM_HEADS,
    parameter int unsigned TMO_CYC  = RESP_TMO_CYC
) (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // apb slave
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [7:0]        paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    // heads
    input  wire logic [HEADS-1:0]  head_req_in,
    input  wire logic [HEADS-1:0]  head_pwm_in,
    output logic      [HEADS-1:0]  stage_en_out,
    output logic      [HEADS-1:0]  pwm_out,
    output logic                   relay_en_out,
    // safety relay contact
    input  wire logic              safety_ok_in,
    // interrupt
    output logic                   irq_out
);
    // poll flags fill one status byte, so eight heads at most
    if (HEADS < 1 || HEADS > 8 || TMO_CYC < 1) begin : g_bad_param
        $error("leit_interlock: unsupported parameter values");
    end

    typedef enum logic [1:0] {LEIT_IDLE, LEIT_MEAS, LEIT_POLL} leit_head_t;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    // writes and read-clears act at the first access edge
    logic acc;
    logic wr;
    logic rd;
    assign acc = psel_in & penable_in & ~pready_out;
    assign wr  = acc & pwrite_in;
    assign rd  = acc & ~pwrite_in;

    function automatic logic is_mtime(input logic [7:0] a);
        return (a >= ADDR_MTIME0) && (a < ADDR_MTIME0 + 8'(4 * HEADS))
               && (a[1:0] == 2'b00);
    endfunction

    function automatic int unsigned mt_idx(input logic [7:0] a);
        return int'((a - ADDR_MTIME0) >> 2);
    endfunction

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic              sw_en_q;
    logic              tmo_q;
    logic              safe_lock_q;
    logic [HEADS-1:0]  head_en_q;
    logic [TIME_W-1:0] mtime_q [HEADS];
    logic [IRQ_W-1:0]  irq_stat_q;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic [HEADS-1:0]  poll_q;
    logic [HEADS-1:0]  head_tmo;
    logic [HEADS-1:0]  head_poll_ev;
    logic [HEADS-1:0]  head_in_poll;
    logic              en_wr;
    logic [HEADS-1:0]  start_w;
    logic [HEADS-1:0]  resp_w;
    logic              any_tmo;
    logic              safe_ok_q;
    logic              relay_d;

    assign start_w = (wr && paddr_in == ADDR_START) ?
                     pwdata_in[HEADS-1:0] : '0;
    assign resp_w  = (wr && paddr_in == ADDR_RESP) ?
                     pwdata_in[HEADS-1:0] : '0;
    assign any_tmo = |head_tmo;
    assign en_wr   = wr && paddr_in == ADDR_CTRL && pwdata_in[CTRL_EN_BIT];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sw_en_q <= 1'b0;
        // open contact refuses enable; the lock clears on the same write
        end else if (any_tmo || !safe_ok_q) begin
            sw_en_q <= 1'b0;
        end else if (wr && paddr_in == ADDR_CTRL) begin
            sw_en_q <= pwdata_in[CTRL_EN_BIT];
        end
    end

    // timeout latch held until software writes enable again
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tmo_q <= 1'b0;
        end else if (any_tmo) begin
            tmo_q <= 1'b1;
        end else if (en_wr) begin
            tmo_q <= 1'b0;
        end
    end

    // safety contact is sampled, never driven
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            safe_ok_q   <= 1'b0;
            safe_lock_q <= 1'b1;
        end else begin
            safe_ok_q <= safety_ok_in;
            if (!safe_ok_q) begin
                safe_lock_q <= 1'b1;
            end else if (en_wr) begin
                // re-arm only after the external relay reset closed the contact
                safe_lock_q <= 1'b0;
            end
        end
    end

    // head enable and mask are plain read-write words
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            head_en_q  <= '0;
            irq_mask_q <= '0;
        end else if (wr) begin
            if (paddr_in == ADDR_HEAD_EN)
                head_en_q <= pwdata_in[HEADS-1:0];
            if (paddr_in == ADDR_IRQ_MASK)
                irq_mask_q <= pwdata_in[IRQ_W-1:0];
        end
    end

    // time in clock cycles; zero still spends one cycle measuring
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < HEADS; i++)
                mtime_q[i] <= '0;
        end else if (wr && is_mtime(paddr_in)) begin
            mtime_q[mt_idx(paddr_in)] <= pwdata_in[TIME_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // per-head measurement and response watchdog
    // ------------------------------------------------------------------
    for (genvar g = 0; g < HEADS; g++) begin : g_head
        leit_head_t        st_q;
        logic [TIME_W-1:0] cnt_q;
        logic [31:0]       tmo_cnt_q;
        // the watchdog runs only while the head owes an answer

        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                st_q      <= LEIT_IDLE;
                cnt_q     <= '0;
                tmo_cnt_q <= '0;
            end else begin
                case (st_q)
                    LEIT_IDLE: begin
                        if (start_w[g] && sw_en_q) begin
                            st_q  <= LEIT_MEAS;
                            cnt_q <= mtime_q[g];
                        end
                    end
                    LEIT_MEAS: begin
                        if (cnt_q == '0) begin
                            st_q      <= LEIT_POLL;
                            tmo_cnt_q <= '0;
                        end else begin
                            cnt_q <= cnt_q - 1'b1;
                        end
                    end
                    LEIT_POLL: begin
                        if (resp_w[g]) begin
                            st_q <= LEIT_IDLE;
                        end else if (tmo_cnt_q == 32'(TMO_CYC - 1)) begin
                            st_q <= LEIT_IDLE;
                        end else begin
                            tmo_cnt_q <= tmo_cnt_q + 32'h0000_0001;
                        end
                    end
                    default: st_q <= LEIT_IDLE;
                endcase
            end
        end

        assign head_tmo[g] = (st_q == LEIT_POLL) && !resp_w[g]
                             && (tmo_cnt_q == 32'(TMO_CYC - 1));
        assign head_poll_ev[g] = (st_q == LEIT_MEAS) && (cnt_q == '0);
        assign head_in_poll[g] = (st_q == LEIT_POLL);
    end

    // one writer for the whole poll field
    always_ff @(posedge clk_in) begin
        if (rst_in)
            poll_q <= '0;
        else
            poll_q <= head_in_poll | head_poll_ev;
    end

    // ------------------------------------------------------------------
    // emission gating
    // ------------------------------------------------------------------
    // one enabled head asking is enough to close the shared relay
    assign relay_d = sw_en_q && !tmo_q && !safe_lock_q && safe_ok_q
                     && (|(head_req_in & head_en_q));

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            relay_en_out <= 1'b0;
            stage_en_out <= '0;
            pwm_out      <= '0;
        end else begin
            relay_en_out <= relay_d;
            stage_en_out <= relay_d ? head_en_q : '0;
            pwm_out      <= (relay_d ? head_en_q : '0)
                            & head_req_in & head_pwm_in;
        end
    end

    // ------------------------------------------------------------------
    // interrupts: set wins over read-clear
    // ------------------------------------------------------------------
    // contact fall against its sampled copy, which is low after reset
    logic [IRQ_W-1:0] ev;
    assign ev = {|head_poll_ev, (safe_ok_q & ~safety_ok_in), any_tmo};

    always_ff @(posedge clk_in) begin
        if (rst_in)
            irq_stat_q <= '0;
        else if (rd && paddr_in == ADDR_IRQ_STAT)
            irq_stat_q <= ev;
        else
            irq_stat_q <= irq_stat_q | ev;
    end

    // level output, one cycle behind the status word
    always_ff @(posedge clk_in) begin
        if (rst_in)
            irq_out <= 1'b0;
        else
            irq_out <= |(irq_stat_q & irq_mask_q);
    end

    // ------------------------------------------------------------------
    // apb response, one wait state
    // ------------------------------------------------------------------
    // registered answer costs a wait state but keeps prdata glitch free
    logic        known;
    logic [31:0] rdat;
    always_comb begin
        rdat  = RST_WORD;
        known = 1'b1;
        case (paddr_in)
            ADDR_CTRL:     rdat[CTRL_EN_BIT] = sw_en_q;
            ADDR_STATUS: begin
                rdat[ST_EN_BIT]    = sw_en_q;
                rdat[ST_TMO_BIT]   = tmo_q;
                rdat[ST_SAFE_BIT]  = safe_ok_q;
                rdat[ST_RELAY_BIT] = relay_en_out;
                rdat[ST_POLL_LSB +: HEADS] = poll_q;
            end
            ADDR_IRQ_STAT: rdat[IRQ_W-1:0] = irq_stat_q;
            ADDR_IRQ_MASK: rdat[IRQ_W-1:0] = irq_mask_q;
            ADDR_HEAD_EN:  rdat[HEADS-1:0] = head_en_q;
            ADDR_START, ADDR_RESP: rdat = RST_WORD;
            default: begin
                if (is_mtime(paddr_in))
                    rdat[TIME_W-1:0] = mtime_q[mt_idx(paddr_in)];
                else
                    known = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= RST_WORD;
        end else begin
            pready_out  <= acc;
            pslverr_out <= acc & ~known;
            prdata_out  <= rd ? rdat : RST_WORD;
        end
    end
endmodule

// file: leit_pkg.sv
// Purpose: constants for the laser enable interlock and timeout block
// Assumes: 125 MHz system clock, APB with 32-bit data
// Notes:   offsets are byte addresses of aligned words
package leit_pkg;
    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned RESP_TMO_MS    = 500;
    localparam int unsigned RESP_TMO_CYC   = RESP_TMO_MS * 1000 * CLK_MHZ;
    localparam int unsigned NUM_HEADS      = 8;
    localparam int unsigned TIME_W         = 32;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] ADDR_HEAD_EN  = 8'h10;
    localparam logic [7:0] ADDR_START    = 8'h14;
    localparam logic [7:0] ADDR_RESP     = 8'h18;
    localparam logic [7:0] ADDR_MTIME0   = 8'h20;

    // ctrl fields
    localparam int unsigned CTRL_EN_BIT  = 0;
    // status fields
    localparam int unsigned ST_EN_BIT    = 0;
    localparam int unsigned ST_TMO_BIT   = 1;
    localparam int unsigned ST_SAFE_BIT  = 2;
    localparam int unsigned ST_RELAY_BIT = 3;
    localparam int unsigned ST_POLL_LSB  = 8;
    // interrupt events
    localparam int unsigned IRQ_W        = 3;
    localparam int unsigned EV_TMO_BIT   = 0;
    localparam int unsigned EV_SAFE_BIT  = 1;
    localparam int unsigned EV_POLL_BIT  = 2;

    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
endpackage

// file: leit_checker.sv
// Purpose: port-level checks for leit_interlock
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every leit_interlock instance
`timescale 1ns/1ps
module leit_checker #(
    parameter int unsigned HEADS = 8
) (
    // clock and reset
    input wire logic             clk_in,
    input wire logic             rst_in,
    // apb
    input wire logic             psel_in,
    input wire logic             penable_in,
    input wire logic [31:0]      prdata_out,
    input wire logic             pready_out,
    input wire logic             pslverr_out,
    // heads and safety
    input wire logic [HEADS-1:0] head_req_in,
    input wire logic [HEADS-1:0] head_pwm_in,
    input wire logic [HEADS-1:0] stage_en_out,
    input wire logic [HEADS-1:0] pwm_out,
    input wire logic             relay_en_out,
    input wire logic             safety_ok_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ------------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------------
    property p_apb_ans;
        psel_in && penable_in && !pready_out |=> pready_out;
    endproperty
    a_apb_ans: assert property (p_apb_ans) else $error("apb no answer");
    property p_apb_pulse;
        pready_out |=> !pready_out;
    endproperty
    a_apb_pulse: assert property (p_apb_pulse) else $error("pready long");
    property p_apb_cause;
        pready_out |-> $past(psel_in && penable_in);
    endproperty
    a_apb_cause: assert property (p_apb_cause) else $error("pready no cause");
    property p_rd_idle;
        !pready_out |-> prdata_out == 32'h0 && !pslverr_out;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("data outside answer");
    // ------------------------------------------------------------------
    // emission gating
    // ------------------------------------------------------------------
    property p_pwm_gate;
        pwm_out == (stage_en_out & $past(head_req_in & head_pwm_in));
    endproperty
    a_pwm_gate: assert property (p_pwm_gate)
        else $error("pwm gate");
    property p_stage_relay;
        !relay_en_out ##1 !relay_en_out |-> stage_en_out == '0;
    endproperty
    a_stage_relay: assert property (p_stage_relay)
        else $error("stage on");
    property p_relay_req;
        relay_en_out |-> $past(head_req_in) != '0;
    endproperty
    a_relay_req: assert property (p_relay_req)
        else $error("relay no req");
    // two cycles: contact is registered, then relay_en_out is registered from it
    property p_safe_off;
        !safety_ok_in |-> ##2 (!relay_en_out && stage_en_out == '0);
    endproperty
    a_safe_off: assert property (p_safe_off)
        else $error("safety off");
endmodule

bind leit_interlock leit_checker #(.HEADS(HEADS)) chk_u (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .head_req_in(head_req_in), .head_pwm_in(head_pwm_in),
    .stage_en_out(stage_en_out), .pwm_out(pwm_out),
    .relay_en_out(relay_en_out), .safety_ok_in(safety_ok_in)
);

// file: leit_head_model.sv
// Purpose: eight measuring heads with own request and pwm
// Assumes: go_in held high by the bench for the whole measurement
// Notes:   measurement limit shortened; a stuck head holds pwm high
`timescale 1ns/1ps
module leit_head_model #(
    parameter int unsigned MEAS_MAX = 4000
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] go_in,
    input  wire logic [7:0] stuck_in,
    output logic      [7:0] req_out,
    output logic      [7:0] pwm_out
);
    int unsigned cnt [8];
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < 8; i++) begin
            if (rst_in || !go_in[i]) cnt[i] <= 0;
            else if (cnt[i] < MEAS_MAX) cnt[i] <= cnt[i] + 1;
            // head stops itself at the limit, toggling keeps duty at half
            if (rst_in) begin
                req_out[i] <= 1'b0;
                pwm_out[i] <= 1'b0;
            end else begin
                req_out[i] <= go_in[i] && cnt[i] < MEAS_MAX;
                pwm_out[i] <= stuck_in[i]
                              | (req_out[i] & !pwm_out[i]);
            end
        end
    end
endmodule

// file: tb_top.sv
// Purpose: self-checking bench for leit_interlock
// Assumes: response timeout shortened to 20 cycles
// Notes:   head 7 is defective, its pwm sticks high
`timescale 1ns/1ps
`define CHK(nm, e, v) begin tests_run++; if ((v) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", nm, e, v); end end
module tb_top;
    import leit_pkg::*;
    logic        clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00, go = 8'h00, stuck = 8'h80;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, relay, irq, safe_ok = 1;
    logic [7:0]  req, hpwm, stage, pwm;
    int          fails = 0, tests_run = 0, cyc = 0;
    initial forever #4 clk_in = ~clk_in;
    leit_interlock #(.TMO_CYC(20)) dut_u (.clk_in(clk_in), .rst_in(rst_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .head_req_in(req),
        .head_pwm_in(hpwm), .stage_en_out(stage), .pwm_out(pwm),
        .relay_en_out(relay), .safety_ok_in(safe_ok), .irq_out(irq));
    leit_head_model head_u (.clk_in(clk_in), .rst_in(rst_in), .go_in(go),
        .stuck_in(stuck), .req_out(req), .pwm_out(hpwm));
    // ------------------------------------------------------------------
    // bus and report
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1;
        // pready ends this wait; if it never comes, only the bench timeout does
        do @(posedge clk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
        apb(0, a, 32'h0);
        `CHK(nm, e, rd);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // about 180 cycles of work; a hang ends here as a failure
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            results();
        end
    end
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rchk(ADDR_STATUS, 32'h4, "status_rst");
        rchk(ADDR_IRQ_MASK, 32'h0, "mask_rst");
        apb(0, 8'h1c, 32'h0);
        `CHK("slverr", 1'b1, err);
        `CHK("rd_unmapped", 32'h0, rd);
        go <= 8'hff;
        repeat (4) @(posedge clk_in);
        `CHK("relay_no_sw", 1'b0, relay);
    endtask
    task automatic t_arm;
        apb(1, ADDR_IRQ_MASK, 32'h7);
        apb(1, ADDR_HEAD_EN, 32'h8f);
        apb(1, ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk_in);
        `CHK("relay_on", 1'b1, relay);
        `CHK("stage_sel", 8'h8f, stage);
        `CHK("pwm_pass", 1'b1, pwm[7]);
        rchk(ADDR_STATUS, 32'hd, "status_on");
        go <= 8'h00;
        repeat (3) @(posedge clk_in);
        `CHK("relay_no_req", 1'b0, relay);
        `CHK("pwm_no_req", 8'h00, pwm & 8'h7f);
        go <= 8'hff;
        repeat (3) @(posedge clk_in);
    endtask
    task automatic t_poll;
        int n;
        apb(1, ADDR_MTIME0, 32'h5);
        apb(1, ADDR_START, 32'h1);
        n = 0;
        do begin
            apb(0, ADDR_STATUS, 32'h0);
            n++;
        end while (rd[ST_POLL_LSB] !== 1'b1 && n < 8);
        `CHK("poll", 1'b1, rd[ST_POLL_LSB]);
        `CHK("irq_poll", 1'b1, irq);
        apb(1, ADDR_RESP, 32'h1);
        rchk(ADDR_STATUS, 32'hd, "status_resp");
        rchk(ADDR_IRQ_STAT, 32'h4, "irq_poll_ev");
        rchk(ADDR_IRQ_STAT, 32'h0, "irq_cleared");
        `CHK("irq_low", 1'b0, irq);
    endtask
    task automatic t_tmo;
        apb(1, ADDR_START, 32'h1);
        repeat (40) @(posedge clk_in);
        `CHK("relay_tmo", 1'b0, relay);
        `CHK("stage_tmo", 8'h00, stage);
        `CHK("pwm_stuck_cut", 8'h00, pwm);
        `CHK("irq_tmo", 1'b1, irq);
        rchk(ADDR_STATUS, 32'h6, "status_tmo");
        rchk(ADDR_IRQ_STAT, 32'h5, "irq_tmo_ev");
        repeat (10) @(posedge clk_in);
        `CHK("relay_held", 1'b0, relay);
        apb(1, ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk_in);
        `CHK("relay_rearm", 1'b1, relay);
    endtask
    task automatic t_safe;
        // emergency stop opens the external contact
        safe_ok <= 0;
        repeat (3) @(posedge clk_in);
        `CHK("relay_fault", 1'b0, relay);
        `CHK("stage_fault", 8'h00, stage);
        safe_ok <= 1;
        repeat (10) @(posedge clk_in);
        `CHK("relay_no_auto", 1'b0, relay);
        rchk(ADDR_IRQ_STAT, 32'h2, "irq_safe_ev");
        apb(1, ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk_in);
        `CHK("relay_reset", 1'b1, relay);
        rchk(ADDR_STATUS, 32'hd, "status_back");
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        rst_in <= 0;
        t_reset();
        t_arm();
        t_poll();
        t_tmo();
        t_safe();
        results();
    end
endmodule
